// ---- src/amc_top.sv ----
// converter mode sequencer, interrupt masking and current channel control behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module amc_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [31:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic conv_done_i,
  input wire logic [31:0] conv_data_i,
  input wire logic period_tick_i,
  input wire logic accum_thr_i,
  input wire logic result_thr_i,
  input wire logic overrange_i,
  input wire logic temp_ready_i,
  input wire logic volt_ready_i,
  output logic irq_o,
  output logic conv_power_o,
  output logic conv_reset_o,
  output logic conv_run_o,
  output logic [2:0] operating_mode_o,
  output logic low_power_select_o,
  output logic [9:0] mod_freq_khz_o,
  output logic current_conv_enable_o,
  output logic [1:0] buffer_bypass_select_o,
  output logic [1:0] aux_diag_current_o,
  output logic [1:0] main_diag_current_o,
  output logic [1:0] gain_stage_scaling_o,
  output logic result_coding_select_o,
  output logic [2:0] current_input_select_o
);
  import amc_pkg::*;

  amc_regs_s s_q;
  amc_regs_s s_d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] mode_word(input amc_regs_s s);
    return {26'h000_0000, s.always_interrupt, 1'b0, s.lp, s.mode};
  endfunction

  function automatic logic [31:0] ctrl_word(input amc_regs_s s);
    return {12'h000, s.en, 1'b0, s.bufbp, s.aux_diag, s.main_diag, s.scale, s.coding, s.insel, 6'h00};
  endfunction

  function automatic amc_state_e mode_state(input logic [2:0] md);
    amc_state_e st;
    case (md)
      MD_PDOWN: begin
        st = ST_PDOWN;
      end
      MD_CONT: begin
        st = ST_CONT;
      end
      MD_SINGLE: begin
        st = ST_SINGLE;
      end
      MD_IDLE: begin
        st = ST_IDLE;
      end
      default: begin
        st = ST_CAL;
      end
    endcase
    return st;
  endfunction

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_do;
  logic wr_mode;
  logic wr_ctrl;
  logic rd_result;
  logic running;
  logic conv_ok;
  logic [31:0] wm;

  assign s_axi_awready_o = clk_en_i && !s_q.aw_v && !s_q.bv;
  assign s_axi_wready_o = clk_en_i && !s_q.w_v && !s_q.bv;
  assign s_axi_arready_o = clk_en_i && !s_q.rv;
  assign s_axi_bvalid_o = s_q.bv;
  assign s_axi_bresp_o = s_q.bresp;
  assign s_axi_rvalid_o = s_q.rv;
  assign s_axi_rdata_o = s_q.rdata;
  assign s_axi_rresp_o = s_q.rresp;

  always_comb begin
    s_d = s_q;
    wm = 32'h0000_0000;
    aw_fire = s_axi_awvalid_i && s_axi_awready_o;
    w_fire = s_axi_wvalid_i && s_axi_wready_o;
    ar_fire = s_axi_arvalid_i && s_axi_arready_o;
    wr_do = s_q.aw_v && s_q.w_v;
    wr_mode = wr_do && (s_q.aw_a == ADDR_MODE);
    wr_ctrl = wr_do && (s_q.aw_a == ADDR_CTRL);
    rd_result = ar_fire && (s_axi_araddr_i == ADDR_RESULT);
    running = (s_q.state != ST_PDOWN) && (s_q.state != ST_IDLE);
    conv_ok = conv_done_i && s_q.en && running;

    // write channel capture, either order
    if (aw_fire) begin
      s_d.aw_v = 1'b1;
      s_d.aw_a = s_axi_awaddr_i;
    end
    if (w_fire) begin
      s_d.w_v = 1'b1;
      s_d.w_d = s_axi_wdata_i;
      s_d.w_s = s_axi_wstrb_i;
    end
    if (s_q.bv && s_axi_bready_i) begin
      s_d.bv = 1'b0;
    end
    if (s_q.rv && s_axi_rready_i) begin
      s_d.rv = 1'b0;
    end

    // read path
    if (ar_fire) begin
      s_d.rv = 1'b1;
      s_d.rresp = AXI_OKAY;
      case (s_axi_araddr_i)
        ADDR_STATUS: begin
          s_d.rdata = {16'h0000, s_q.cal_done, 8'h00, s_q.flags};
        end
        ADDR_MASK: begin
          s_d.rdata = {25'h000_0000, s_q.mask};
        end
        ADDR_MODE: begin
          s_d.rdata = mode_word(s_q);
        end
        ADDR_CTRL: begin
          s_d.rdata = ctrl_word(s_q);
        end
        ADDR_RESULT: begin
          s_d.rdata = s_q.result;
        end
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = AXI_SLVERR;
        end
      endcase
    end

    // clears from software come first so that hardware sets below win
    if (rd_result) begin
      s_d.flags[FLG_CUR] = 1'b0;
      s_d.flags[FLG_TEMP] = 1'b0;
      s_d.flags[FLG_VOLT] = 1'b0;
      s_d.flags[FLG_TICK] = 1'b0;
    end
    if (wr_ctrl) begin
      // reconfiguring the channel drops its result and comparator flags
      s_d.flags[FLG_CUR] = 1'b0;
      s_d.flags[FLG_THR] = 1'b0;
      s_d.flags[FLG_ACC] = 1'b0;
      s_d.flags[FLG_OVR] = 1'b0;
    end
    if (wr_ctrl || wr_mode) begin
      s_d.cal_done = 1'b0;
    end

    // sequencer
    case (s_q.state)
      ST_CONT: begin
        if (conv_ok && !s_q.flags[FLG_CUR]) begin
          s_d.result = conv_data_i;
          s_d.flags[FLG_CUR] = 1'b1;
        end
      end
      ST_SINGLE: begin
        if (conv_ok) begin
          s_d.result = conv_data_i;
          s_d.flags[FLG_CUR] = 1'b1;
          s_d.mode = MD_IDLE;
        end
      end
      ST_CAL: begin
        // offset, self gain, system zero and system full-scale all end the same way
        if (conv_ok) begin
          s_d.result = conv_data_i;
          s_d.flags[FLG_CUR] = 1'b1;
          s_d.cal_done = 1'b1;
          s_d.mode = MD_IDLE;
        end
      end
      ST_PDOWN: begin
        s_d.mode = s_q.mode;
      end
      ST_IDLE: begin
        s_d.mode = s_q.mode;
      end
      default: begin
        s_d.mode = MD_IDLE;
      end
    endcase
    if (running && s_q.always_interrupt && period_tick_i) begin
      s_d.flags[FLG_TICK] = 1'b1;
    end
    if (running && accum_thr_i) begin
      s_d.flags[FLG_ACC] = 1'b1;
    end
    if (running && result_thr_i) begin
      s_d.flags[FLG_THR] = 1'b1;
    end
    if (running && overrange_i) begin
      s_d.flags[FLG_OVR] = 1'b1;
    end
    if (running && temp_ready_i) begin
      s_d.flags[FLG_TEMP] = 1'b1;
    end
    if (running && volt_ready_i) begin
      s_d.flags[FLG_VOLT] = 1'b1;
    end

    // register writes
    if (wr_do) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.bv = 1'b1;
      s_d.bresp = AXI_OKAY;
      case (s_q.aw_a)
        ADDR_MASK: begin
          wm = merge({25'h000_0000, s_q.mask}, s_q.w_d, s_q.w_s);
          s_d.mask = wm[6:0];
        end
        ADDR_MODE: begin
          wm = merge(mode_word(s_q), s_q.w_d, s_q.w_s);
          s_d.always_interrupt = wm[MODE_ALWAYS_INTERRUPT_POS];
          s_d.lp = wm[MODE_LP_POS];
          s_d.mode = wm[2:0];
        end
        ADDR_CTRL: begin
          wm = merge(ctrl_word(s_q), s_q.w_d, s_q.w_s);
          s_d.en = wm[CTRL_EN_POS];
          s_d.bufbp = wm[CTRL_BUF_POS +: 2];
          s_d.aux_diag = wm[CTRL_AUX_POS +: 2];
          s_d.main_diag = wm[CTRL_MAIN_POS +: 2];
          s_d.scale = wm[CTRL_SCALE_POS +: 2];
          s_d.coding = wm[CTRL_CODE_POS];
          s_d.insel = wm[CTRL_INSEL_POS +: 3];
        end
        ADDR_STATUS: begin
          s_d.bresp = AXI_OKAY;
        end
        ADDR_RESULT: begin
          s_d.bresp = AXI_OKAY;
        end
        default: begin
          s_d.bresp = AXI_SLVERR;
        end
      endcase
    end

    // a disabled channel holds no ready result, even if one finished this cycle
    if (!s_d.en) begin
      s_d.flags[FLG_CUR] = 1'b0;
    end
    s_d.state = mode_state(s_d.mode);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.mask <= MASK_RST;
      s_q.mode <= MODE_RST;
      s_q.state <= ST_IDLE;
      s_q.en <= CTRL_RST[CTRL_EN_POS];
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // seven masked sources onto one line
  assign irq_o = |(s_q.flags & s_q.mask);
  assign conv_power_o = (s_q.state != ST_PDOWN);
  assign conv_reset_o = (s_q.state == ST_IDLE) || (s_q.state == ST_PDOWN);
  assign conv_run_o = (s_q.state != ST_PDOWN) && (s_q.state != ST_IDLE) && s_q.en;
  assign operating_mode_o = s_q.mode;
  assign low_power_select_o = s_q.lp;
  assign mod_freq_khz_o = s_q.lp ? MOD_KHZ_LOW : MOD_KHZ_NORMAL;
  assign current_conv_enable_o = s_q.en && (s_q.state != ST_PDOWN);
  assign buffer_bypass_select_o = s_q.bufbp;
  assign aux_diag_current_o = s_q.aux_diag;
  assign main_diag_current_o = s_q.main_diag;
  assign gain_stage_scaling_o = s_q.scale;
  assign result_coding_select_o = s_q.coding;
  assign current_input_select_o = s_q.insel;
endmodule
`default_nettype wire

// ---- src/amc_pkg.sv ----
// constants, state and register layout for the converter mode and interrupt control block
// Function
// - periodic tick flag interrupts only while mask bit 6 is one; default off
// - mask bit 5 gates the accumulator threshold flag onto the interrupt
// - mask bit 4 gates the result threshold flag; default zero after reset
// - mask bit 3 gates the fast overrange flag onto the interrupt
// - mask bits 2,1,0 gate temperature, voltage and current ready flags
// - always-interrupt mode sets tick flag one output period after conversion start
// - mode bit 3 picks normal 512 kHz or low-power 128 kHz modulator
// - mode 000 powers down converters and gain stage
// - mode 001 converts continuously; result written only when ready flag clear
// - mode 010 converts once, then mode returns to idle after ready
// - mode 011 is reset value: powered, held in reset; calibrations end here
// - mode 100 self offset calibration; result stored, ready and cal-done set, idle
// - mode 110 system zero-scale calibration writes result to data register
// - mode 111 system full-scale calibration; never with internal temperature sensor
// - control bit 19 enables converter; clearing powers down and clears ready
// - bits 17:16 select input buffer bypass: none, negative, positive, both
// - bits 15:14 and 13:12 drive aux and main 50 uA diagnostic currents
// - bits 11:10 select gain stage output scaling; software compensates results
// - control bit 9 selects bipolar or unipolar result coding
// - bits 8:6 select current input; values 100 to 111 reserved
// - current ready set at conversion end while enabled; cleared by result read
package amc_pkg;
  localparam logic [31:0] ADDR_STATUS = 32'h4003_0000;
  localparam logic [31:0] ADDR_MASK = 32'h4003_0004;
  localparam logic [31:0] ADDR_MODE = 32'h4003_0008;
  localparam logic [31:0] ADDR_CTRL = 32'h4003_000C;
  localparam logic [31:0] ADDR_RESULT = 32'h4003_0020;
  localparam logic [6:0] MASK_RST = 7'h00;
  localparam logic [2:0] MODE_RST = 3'h3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [2:0] MD_PDOWN = 3'h0;
  localparam logic [2:0] MD_CONT = 3'h1;
  localparam logic [2:0] MD_SINGLE = 3'h2;
  localparam logic [2:0] MD_IDLE = 3'h3;
  localparam logic [2:0] MD_SELF_OFS = 3'h4;
  localparam logic [2:0] MD_SELF_GAIN = 3'h5;
  localparam logic [2:0] MD_SYS_ZERO = 3'h6;
  localparam logic [2:0] MD_SYS_GAIN = 3'h7;
  localparam int FLG_TICK = 6;
  localparam int FLG_ACC = 5;
  localparam int FLG_THR = 4;
  localparam int FLG_OVR = 3;
  localparam int FLG_TEMP = 2;
  localparam int FLG_VOLT = 1;
  localparam int FLG_CUR = 0;
  localparam int STA_CAL_POS = 15;
  localparam int MODE_ALWAYS_INTERRUPT_POS = 5;
  localparam int MODE_LP_POS = 3;
  localparam int CTRL_EN_POS = 19;
  localparam int CTRL_BUF_POS = 16;
  localparam int CTRL_AUX_POS = 14;
  localparam int CTRL_MAIN_POS = 12;
  localparam int CTRL_SCALE_POS = 10;
  localparam int CTRL_CODE_POS = 9;
  localparam int CTRL_INSEL_POS = 6;
  localparam logic [9:0] MOD_KHZ_NORMAL = 10'h200;
  localparam logic [9:0] MOD_KHZ_LOW = 10'h080;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_PDOWN = 3'b000,
    ST_IDLE = 3'b001,
    ST_CONT = 3'b011,
    ST_SINGLE = 3'b010,
    ST_CAL = 3'b110
  } amc_state_e;

  typedef struct packed {
    logic [6:0] mask;
    logic always_interrupt;
    logic lp;
    logic [2:0] mode;
    logic en;
    logic [1:0] bufbp;
    logic [1:0] aux_diag;
    logic [1:0] main_diag;
    logic [1:0] scale;
    logic coding;
    logic [2:0] insel;
    logic [6:0] flags;
    logic cal_done;
    logic [31:0] result;
    amc_state_e state;
    logic aw_v;
    logic [31:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bv;
    logic [1:0] bresp;
    logic rv;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } amc_regs_s;
endpackage

// ---- test/amc_properties.sv ----
// concurrent checks on the ports of the converter mode and interrupt control block
`timescale 1ns/10ps
`default_nettype none
module amc_properties (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic s_axi_bvalid_o,
  input wire logic conv_done_i,
  input wire logic irq_o,
  input wire logic conv_power_o,
  input wire logic conv_reset_o,
  input wire logic conv_run_o,
  input wire logic [2:0] operating_mode_o,
  input wire logic low_power_select_o,
  input wire logic [9:0] mod_freq_khz_o,
  input wire logic current_conv_enable_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic ev_ok = conv_done_i && current_conv_enable_o && clk_en_i;
  a_freq_select: assert property (mod_freq_khz_o == (low_power_select_o ? 10'h080 : 10'h200))
    else $error("modulator rate does not follow power mode");
  a_pdown_off: assert property (operating_mode_o == 3'h0 |-> !conv_power_o && !current_conv_enable_o)
    else $error("converter powered in power-down");
  a_idle_held: assert property (operating_mode_o == 3'h3 |-> conv_reset_o && !conv_run_o)
    else $error("idle does not hold converter in reset");
  a_cont_runs: assert property (operating_mode_o == 3'h1 && current_conv_enable_o |-> conv_run_o)
    else $error("continuous mode not running");
  a_cont_stays: assert property (operating_mode_o == 3'h1 && ev_ok
    |=> operating_mode_o == 3'h1 || $rose(s_axi_bvalid_o))
    else $error("continuous mode left after a result");
  a_single_idle: assert property (operating_mode_o == 3'h2 && ev_ok
    |=> operating_mode_o == 3'h3 || $rose(s_axi_bvalid_o))
    else $error("single conversion did not return to idle");
  a_cal_idle: assert property (operating_mode_o[2] && ev_ok
    |=> operating_mode_o == 3'h3 || $rose(s_axi_bvalid_o))
    else $error("calibration did not return to idle");
  a_enable_gate: assert property (!current_conv_enable_o |-> !conv_run_o)
    else $error("disabled converter running");
  a_irq_quiet: assert property ($rose(rst_n_i) |-> !irq_o)
    else $error("interrupt high after reset");
  c_single_idle: cover property (operating_mode_o == 3'h2 ##1 operating_mode_o == 3'h3);
  c_irq: cover property ($rose(irq_o));
  c_low_power: cover property (low_power_select_o);
endmodule
`default_nettype wire

// ---- test/tb_amc_top.sv ----
// register-level testbench of the converter mode and interrupt control block
`timescale 1ns/10ps
`default_nettype none
module tb_amc_top;
  import amc_pkg::*;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, ce = 1;
  logic [3:0] ws = 4'hF;
  logic [31:0] awa = 0, wd = 0, ara = 0, cd = 0, d;
  logic [6:0] ev = 0;
  logic [1:0] r;
  logic [31:0] cv [2] = '{32'h0001_B8C0, 32'h000B_6740};
  wire logic awr, wrd, bv, arr, rv, irq, pw, rs, run, lp, en, code;
  wire logic [1:0] brsp, rrsp, bb, ax, mn, sc;
  wire logic [2:0] md, ins;
  wire logic [9:0] fk;
  wire logic [31:0] rdat;
  int n_mismatch = 0, total_checks = 0, cyc = 0, i;
  always #4 clk = ~clk;
  amc_top amc_top_inst (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(ce),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_bresp_o(brsp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rrsp), .conv_done_i(ev[0]), .conv_data_i(cd), .period_tick_i(ev[6]),
    .accum_thr_i(ev[5]), .result_thr_i(ev[4]), .overrange_i(ev[3]), .temp_ready_i(ev[2]),
    .volt_ready_i(ev[1]), .irq_o(irq), .conv_power_o(pw), .conv_reset_o(rs), .conv_run_o(run),
    .operating_mode_o(md), .low_power_select_o(lp), .mod_freq_khz_o(fk), .current_conv_enable_o(en),
    .buffer_bypass_select_o(bb), .aux_diag_current_o(ax), .main_diag_current_o(mn),
    .gain_stage_scaling_o(sc), .result_coding_select_o(code), .current_input_select_o(ins));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clk);
    awv <= 1;
    awa <= a;
    wv <= 1;
    wd <= v;
    br <= 1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrd;
      tb = bv;
      r = brsp;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end while (!tb);
    br <= 0;
  endtask
  task automatic rd(input logic [31:0] a);
    logic ta, tr;
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rr <= 1;
    do begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      d = rdat;
      r = rrsp;
      @(posedge clk);
      if (ta) arv <= 0;
    end while (!tr);
    rr <= 0;
  endtask
  task automatic pulse(input logic [6:0] e, input logic [31:0] v);
    @(posedge clk);
    ev <= e;
    cd <= v;
    @(posedge clk);
    ev <= 0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      complete_run;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    rd(ADDR_MASK);
    chk("mask", d, 0);
    rd(ADDR_MODE);
    chk("mode", d, 32'h3);
    rd(ADDR_CTRL);
    chk("ctrl", d, 0);
    @(negedge clk);
    chk("power", {lp, fk}, {1'b0, 10'h200});
    chk("idle pins", {pw, rs, run, md}, {3'b110, 3'h3});
    rd(32'h4003_0010);
    chk("rresp", r, AXI_SLVERR);
    wr(ADDR_MODE, 32'h21);
    wr(ADDR_CTRL, 32'h0008_0000);
    @(negedge clk);
    chk("cont pins", {pw, rs, run, md}, {3'b101, 3'h1});
    for (i = 0; i < 7; i++) begin
      wr(ADDR_MASK, ~(32'h1 << i) & 32'h7F);
      pulse(7'h1 << i, 0);
      @(negedge clk);
      chk("irq off", irq, 0);
      rd(ADDR_STATUS);
      chk("flag", d[6:0], 7'h1 << i);
      wr(ADDR_MASK, 32'h1 << i);
      @(negedge clk);
      chk("irq on", irq, 1);
      wr(ADDR_CTRL, 32'h0008_0000);
      rd(ADDR_RESULT);
    end
    pulse(1, 32'hA5A5_0001);
    pulse(1, 32'h5A5A_0002);
    rd(ADDR_RESULT);
    chk("cont", d, 32'hA5A5_0001);
    pulse(1, 32'h3);
    rd(ADDR_RESULT);
    chk("cont next", d, 32'h3);
    pulse(1, 32'h4);
    wr(ADDR_CTRL, 0);
    pulse(1, 32'h5);
    rd(ADDR_STATUS);
    chk("rdy off", d[0], 0);
    chk("en off", {en, run}, 0);
    wr(ADDR_CTRL, 32'h0008_0000);
    wr(ADDR_MODE, 32'h2);
    pulse(1, 32'h1234_5678);
    rd(ADDR_MODE);
    chk("single", d, 32'h3);
    @(negedge clk);
    chk("single pins", {rs, run, md}, {2'b10, 3'h3});
    rd(ADDR_STATUS);
    chk("single rdy", d[0], 1);
    rd(ADDR_RESULT);
    chk("single res", d, 32'h1234_5678);
    // each calibration mode 100 to 111 stores its result, sets ready and cal-done, and returns to idle
    for (i = 4; i < 8; i++) begin
      wr(ADDR_MODE, i);
      pulse(1, i + 32'h100);
      rd(ADDR_STATUS);
      chk("cal sta", {d[15], d[0]}, 2'b11);
      rd(ADDR_MODE);
      chk("cal idle", d, 32'h3);
      rd(ADDR_RESULT);
      chk("cal res", d, i + 32'h100);
    end
    wr(ADDR_MODE, 32'h3);
    rd(ADDR_STATUS);
    chk("cal clr", d[15], 0);
    for (i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, cv[i]);
      @(negedge clk);
      chk("fields", {en, bb, ax, mn, sc, code, ins}, {cv[i][19], cv[i][17:6]});
      rd(ADDR_CTRL);
      chk("ctrl rb", d, cv[i]);
    end
    wr(ADDR_MODE, 32'h0B);
    @(negedge clk);
    chk("low power", {lp, fk}, {1'b1, 10'h080});
    wr(ADDR_MODE, 0);
    @(negedge clk);
    chk("pdown", {pw, en}, 0);
    wr(32'h4003_0010, 1);
    chk("bresp", r, AXI_SLVERR);
    // a conversion offered while the clock enable is low must leave no trace
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_MASK, 32'h1);
    @(posedge clk);
    ce <= 0;
    pulse(1, 32'h77);
    @(negedge clk);
    chk("frozen", {irq, awr, arr}, 0);
    @(posedge clk);
    ce <= 1;
    rd(ADDR_STATUS);
    chk("frozen flag", d[0], 0);
    pulse(1, 32'h78);
    @(negedge clk);
    chk("irq after", irq, 1);
    rd(ADDR_RESULT);
    chk("result after", d, 32'h78);
    ws <= 4'h4;
    wr(ADDR_CTRL, 32'h0000_0000);
    ws <= 4'hF;
    rd(ADDR_CTRL);
    chk("strobe", d, 32'h0000_6740);
    complete_run;
  end
endmodule
bind amc_top amc_properties amc_properties_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .clk_en_i(clk_en_i), .s_axi_bvalid_o(s_axi_bvalid_o), .conv_done_i(conv_done_i), .irq_o(irq_o),
  .conv_power_o(conv_power_o), .conv_reset_o(conv_reset_o), .conv_run_o(conv_run_o),
  .operating_mode_o(operating_mode_o), .low_power_select_o(low_power_select_o),
  .mod_freq_khz_o(mod_freq_khz_o), .current_conv_enable_o(current_conv_enable_o));
`default_nettype wire
